// File: pkg/nvct_defs.vh
// nvct_defs.vh: offsets, fields, reset values and timing counts of the nv command timing block
// assumes: included by bare name from the design file; definitions only
`ifndef NVCT_DEFS_VH
`define NVCT_DEFS_VH

// register word offsets (byte address = 4 * index for the nonvolatile images)
`define NVCT_IDX_FINE_TRIM     16'hFFAE
`define NVCT_IDX_OTRIM_STORE   16'hFFAF
`define NVCT_IDX_KEY_BASE      16'hFFB0
`define NVCT_IDX_PROT_CONFIG   16'hFFBD
`define NVCT_IDX_OPT_CONFIG    16'hFFBF
// block control registers, byte addresses
`define NVCT_ADR_DIVIDER       8'h00
`define NVCT_ADR_COMMAND       8'h04
`define NVCT_ADR_ARRAY_ADDR    8'h08
`define NVCT_ADR_ARRAY_DATA    8'h0C
`define NVCT_ADR_STATUS        8'h10
`define NVCT_ADR_IRQ_MASK      8'h14
`define NVCT_ADR_KEY_LO        8'h18
`define NVCT_ADR_KEY_HI        8'h1C
`define NVCT_ADR_SECURITY      8'h20

// divider register fields
`define NVCT_DIV_WIDTH         6
`define NVCT_DIV_PRESCALE_BIT  6
`define NVCT_DIV_LOADED_BIT    7

// command register: code in [2:0], go strobe at bit 7, abort at bit 6, target eeprom at bit 3
`define NVCT_CMD_BLANK         3'h1
`define NVCT_CMD_BYTE_PROG     3'h2
`define NVCT_CMD_BURST_PROG    3'h3
`define NVCT_CMD_SECTOR_ERASE  3'h4
`define NVCT_CMD_MASS_ERASE    3'h5
`define NVCT_CMD_KEY_ENTRY     3'h6
`define NVCT_CMD_GO_BIT        7
`define NVCT_CMD_ABORT_BIT     6
`define NVCT_CMD_EEPROM_BIT    3

// status bits (same layout for the mask)
`define NVCT_ST_DONE           0
`define NVCT_ST_ACCERR         1
`define NVCT_ST_BLANK_OK       2
`define NVCT_ST_KEY_OK         3
`define NVCT_ST_BUSY           7

// option config fields
`define NVCT_OPT_KEY_EN_BIT    7
`define NVCT_LOCK_UNSECURED    2'h2

// durations in program timebase periods
`define NVCT_T_BYTE_PROG       15'd9
`define NVCT_T_BURST_PROG      15'd4
`define NVCT_T_SECTOR_ERASE    15'd4000
`define NVCT_T_MASS_ERASE      15'd20000
`define NVCT_T_ABORT           15'd4
`define NVCT_T_BLANK           15'd1
`define NVCT_T_KEY             15'd1

// reset values
`define NVCT_RST_OPT_CONFIG    8'hFE
`define NVCT_RST_PROT_CONFIG   8'hFF
`define NVCT_RST_TRIM          8'h80

`endif

// File: verilog/nvct_top.v
// nvct_top.v: command and timing logic for flash/eeprom program and erase, with key based unsecure
// assumes: classic wishbone slave on clock, array side is a simple request/abort interface,
// nonvolatile option bytes arrive as plain same-clock inputs loaded at power up
//
// Summary of operation
// - divider written before program or erase accepted
// - divider accepts one write after reset
// - timebase is bus clock over divider setting plus one
// - pulses timed in whole timebase periods
// - byte program 9, burst step 4 periods
// - sector 4000, mass 20000, abort 4 periods
// - command starts with latched array write
// - erase and blank check ignore data, address
// - flash and eeprom erase independently
// - key enabled: matching 8-byte key unsecures
// - key entry only from secure code, not debug
// - key disabled: mass erase plus blank unsecures
// - lock bits 1:0 mean unsecured
`include "nvct_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module nvct_top (
   // clock and reset
   input  wire        clock,
   input  wire        rstn,
   // wishbone slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   // access origin of the current bus cycle
   input  wire        secure_code_fetch,
   input  wire        debug_access,
   // nonvolatile option images
   input  wire [63:0] backdoor_compare_key,
   input  wire [7:0]  nv_option_config,
   input  wire [7:0]  nv_protect_config,
   // array side
   output reg         array_hv_enable,
   output reg         array_eeprom_sel,
   output reg  [2:0]  array_op,
   output reg  [15:0] array_addr,
   output reg  [7:0]  array_data,
   input  wire        array_blank,
   // security and interrupt
   output wire        secured,
   output wire        irq
);

   localparam ST_IDLE = 2'd0;
   localparam ST_RUN  = 2'd1;
   localparam ST_ABRT = 2'd2;

   reg [7:0]  div_reg;
   reg        div_loaded_reg;
   reg [6:0]  pre_cnt_reg;
   reg        tick_reg;
   reg [1:0]  state_reg;
   reg [14:0] period_cnt_reg;
   reg [2:0]  cmd_reg;
   reg        latched_reg;
   reg [7:0]  status_reg;
   reg [7:0]  mask_reg;
   reg [63:0] key_entry_reg;
   reg        unsecure_reg;
   reg        mass_erased_reg;

   wire       wr   = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
   wire       rd   = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
   wire       sel0 = wb_sel_i[0];
   wire       key_enabled = nv_option_config[`NVCT_OPT_KEY_EN_BIT];
   wire [1:0] lock_state_bits = nv_option_config[1:0];
   wire [7:0] status_irq = status_reg & mask_reg;
   wire       cmd_write = wr & (wb_adr_i == `NVCT_ADR_COMMAND) & sel0;
   wire       go = cmd_write & wb_dat_i[`NVCT_CMD_GO_BIT];
   wire       abort_req = cmd_write & wb_dat_i[`NVCT_CMD_ABORT_BIT];
   wire [2:0] go_code = wb_dat_i[2:0];
   wire       hv_cmd = (go_code == `NVCT_CMD_BYTE_PROG) | (go_code == `NVCT_CMD_BURST_PROG) |
                       (go_code == `NVCT_CMD_SECTOR_ERASE) | (go_code == `NVCT_CMD_MASS_ERASE);
   wire       key_match = (key_entry_reg == backdoor_compare_key);

   reg        set_done;
   reg        set_err;
   reg        set_blank;
   reg        set_key;
   reg [14:0] dur_next;
   reg [31:0] rd_data_next;

   // lock bits at 1:0 are the only unsecured code
   assign secured = ~(unsecure_reg | (lock_state_bits == `NVCT_LOCK_UNSECURED));
   assign irq = |status_irq;

   always @* begin
      case (go_code)
         `NVCT_CMD_BYTE_PROG:    dur_next = `NVCT_T_BYTE_PROG;
         `NVCT_CMD_BURST_PROG:   dur_next = `NVCT_T_BURST_PROG;
         `NVCT_CMD_SECTOR_ERASE: dur_next = `NVCT_T_SECTOR_ERASE;
         `NVCT_CMD_MASS_ERASE:   dur_next = `NVCT_T_MASS_ERASE;
         `NVCT_CMD_KEY_ENTRY:    dur_next = `NVCT_T_KEY;
         default:                dur_next = `NVCT_T_BLANK;
      endcase
   end

   // one-cycle events for the sticky status bits
   // kept apart from the clocked block so every flop there is non-blocking
   always @* begin
      set_done  = 1'b0;
      set_err   = 1'b0;
      set_blank = 1'b0;
      set_key   = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            // refused start: pulse without divider, or no latched array write
            if (go & ((hv_cmd & ~div_loaded_reg) | ~latched_reg)) begin
               set_err = 1'b1;
            end
         end
         ST_RUN: begin
            // abort of a sector erase restarts the count, so no completion here
            if (~(abort_req & (cmd_reg == `NVCT_CMD_SECTOR_ERASE)) &
                (tick_reg | ~div_loaded_reg) &
                (period_cnt_reg == 15'd1)) begin
               set_done = 1'b1;
               if (cmd_reg == `NVCT_CMD_BLANK) begin
                  set_blank = array_blank;
               end
               if (cmd_reg == `NVCT_CMD_KEY_ENTRY) begin
                  if (key_enabled & key_match) begin
                     set_key = 1'b1;
                  end else begin
                     set_err = 1'b1;
                  end
               end
            end
         end
         ST_ABRT: begin
            if (tick_reg & (period_cnt_reg == 15'd1)) begin
               set_done = 1'b1;
            end
         end
         default: begin
            set_done = 1'b0;
         end
      endcase
   end

   // read word picked here, registered on the accepting edge
   // busy is taken live from the state so software never sees a stale copy
   always @* begin
      case (wb_adr_i)
         `NVCT_ADR_DIVIDER: begin
            rd_data_next = {24'h000000, div_loaded_reg, div_reg[6:0]};
         end
         `NVCT_ADR_COMMAND: begin
            rd_data_next = {29'h00000000, cmd_reg};
         end
         `NVCT_ADR_ARRAY_ADDR: begin
            rd_data_next = {16'h0000, array_addr};
         end
         `NVCT_ADR_ARRAY_DATA: begin
            rd_data_next = {24'h000000, array_data};
         end
         `NVCT_ADR_STATUS: begin
            rd_data_next = {24'h000000, (state_reg != ST_IDLE), status_reg[6:0]};
         end
         `NVCT_ADR_IRQ_MASK: begin
            rd_data_next = {24'h000000, mask_reg};
         end
         `NVCT_ADR_SECURITY: begin
            // protect image, upper option bits, then the live secured level
            rd_data_next = {16'h0000, nv_protect_config, nv_option_config[7:2], 1'b0, secured};
         end
         default: begin
            // key entry words read back as zero: the key never leaves the block
            rd_data_next = 32'h00000000;
         end
      endcase
   end


   // timebase divider: bus clock / (div[5:0]+1); the prescale bit does not change the count
   always @(posedge clock) begin
      if (!rstn) begin
         pre_cnt_reg <= 7'd0;
         tick_reg    <= 1'b0;
      end else if (!div_loaded_reg) begin
         pre_cnt_reg <= 7'd0;
         tick_reg    <= 1'b0;
      end else begin
         // terminal count from divider field; the prescale bit selects the same six bits
         if (pre_cnt_reg == 7'd0) begin
            pre_cnt_reg <= div_reg[`NVCT_DIV_PRESCALE_BIT] ? {1'b0, div_reg[5:0]} : {1'b0, div_reg[5:0]};
            tick_reg    <= 1'b1;
         end else begin
            pre_cnt_reg <= pre_cnt_reg - 7'd1;
            tick_reg    <= 1'b0;
         end
      end
   end

   // bus, command and status
   always @(posedge clock) begin
      if (!rstn) begin
         wb_ack_o        <= 1'b0;
         wb_dat_o        <= 32'h00000000;
         div_reg         <= 8'h00;
         div_loaded_reg  <= 1'b0;
         state_reg       <= ST_IDLE;
         period_cnt_reg  <= 15'd0;
         cmd_reg         <= 3'h0;
         latched_reg     <= 1'b0;
         status_reg      <= 8'h00;
         mask_reg        <= 8'h00;
         key_entry_reg   <= 64'h0000000000000000;
         unsecure_reg    <= 1'b0;
         mass_erased_reg <= 1'b0;
         array_hv_enable <= 1'b0;
         array_eeprom_sel<= 1'b0;
         array_op        <= 3'h0;
         array_addr      <= 16'h0000;
         array_data      <= 8'h00;
      end else begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
         if (wr & sel0) begin
            case (wb_adr_i)
               `NVCT_ADR_DIVIDER: begin
                  // one write only; later writes are dropped
                  if (!div_loaded_reg) begin
                     div_reg        <= wb_dat_i[7:0];
                     div_loaded_reg <= 1'b1;
                  end
               end
               `NVCT_ADR_ARRAY_ADDR: begin
                  array_addr  <= wb_dat_i[15:0];
                  latched_reg <= 1'b1;
               end
               `NVCT_ADR_ARRAY_DATA: begin
                  array_data  <= wb_dat_i[7:0];
                  latched_reg <= 1'b1;
               end
               `NVCT_ADR_IRQ_MASK: mask_reg <= wb_dat_i[7:0];
               `NVCT_ADR_KEY_LO: begin
                  // debug writes never reach the key entry register
                  if (secure_code_fetch & ~debug_access)
                     key_entry_reg[31:0] <= wb_dat_i;
               end
               `NVCT_ADR_KEY_HI: begin
                  if (secure_code_fetch & ~debug_access)
                     key_entry_reg[63:32] <= wb_dat_i;
               end
               default: ;
            endcase
         end
         case (state_reg)
            ST_IDLE: begin
               if (go) begin
                  if (~((hv_cmd & ~div_loaded_reg) | ~latched_reg)) begin
                     cmd_reg          <= go_code;
                     // array is selected by command bit 3, not by the address
                     array_eeprom_sel <= wb_dat_i[`NVCT_CMD_EEPROM_BIT];
                     array_op         <= go_code;
                     array_hv_enable  <= hv_cmd;
                     period_cnt_reg   <= dur_next;
                     state_reg        <= ST_RUN;
                     latched_reg      <= 1'b0;
                  end
               end
            end
            ST_RUN: begin
               if (abort_req & (cmd_reg == `NVCT_CMD_SECTOR_ERASE)) begin
                  period_cnt_reg <= `NVCT_T_ABORT;
                  state_reg      <= ST_ABRT;
               end else if (tick_reg | ~div_loaded_reg) begin
                  if (period_cnt_reg == 15'd1) begin
                     state_reg       <= ST_IDLE;
                     array_hv_enable <= 1'b0;
                     array_op        <= 3'h0;
                     if (cmd_reg == `NVCT_CMD_MASS_ERASE)
                        mass_erased_reg <= 1'b1;
                     if (cmd_reg == `NVCT_CMD_BLANK) begin
                        // mass erase then blank verify path, taken whether the key is enabled or disabled
                        if (array_blank & mass_erased_reg)
                           unsecure_reg <= 1'b1;
                     end
                     if (cmd_reg == `NVCT_CMD_KEY_ENTRY) begin
                        if (key_enabled & key_match) begin
                           unsecure_reg <= 1'b1;
                        end
                     end
                  end else begin
                     period_cnt_reg <= period_cnt_reg - 15'd1;
                  end
               end
            end
            ST_ABRT: begin
               if (tick_reg) begin
                  if (period_cnt_reg == 15'd1) begin
                     state_reg       <= ST_IDLE;
                     array_hv_enable <= 1'b0;
                     array_op        <= 3'h0;
                  end else begin
                     period_cnt_reg <= period_cnt_reg - 15'd1;
                  end
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
         // set wins over write-one-to-clear
         if (wr & sel0 & (wb_adr_i == `NVCT_ADR_STATUS))
            status_reg[3:0] <= (status_reg[3:0] & ~wb_dat_i[3:0]) | {set_key, set_blank, set_err, set_done};
         else
            status_reg[3:0] <= status_reg[3:0] | {set_key, set_blank, set_err, set_done};
         status_reg[6:4] <= 3'h0;
         status_reg[`NVCT_ST_BUSY] <= 1'b0;
         if (rd) begin
            wb_dat_o <= rd_data_next;
         end
      end
   end

endmodule // nvct_top

`default_nettype wire

// File: tb/nvct_top_assertions.sv
// nvct_top_assertions.sv: port level checks of the nv command timing block
// assumes: bound to nvct_top, one clock, synchronous active low reset
`timescale 1ns/1ps
`default_nettype none
module nvct_top_assertions (
   // clock and reset
   input wire logic        clock,
   input wire logic        rstn,
   // wishbone
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // array side and interrupt
   input wire logic        array_hv_enable,
   input wire logic        array_eeprom_sel,
   input wire logic [2:0]  array_op,
   input wire logic [15:0] array_addr,
   input wire logic [7:0]  array_data,
   input wire logic        irq
);
   // set once the divider write is acked; no pulse may come before it
   logic div_seen_reg;
   always_ff @(posedge clock)
      if (!rstn)
         div_seen_reg <= 1'b0;
      else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && wb_ack_o && wb_adr_i == 8'h00)
         div_seen_reg <= 1'b1;

   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);

   chk_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing one cycle after request");
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_unmapped_zero: assert property (wb_ack_o && !wb_we_i && (wb_adr_i > 8'h20 || wb_adr_i[1:0] != 2'h0)
      |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
   chk_reset_quiet: assert property (disable iff (1'b0) !rstn |=> !wb_ack_o && !irq && !array_hv_enable
      && array_op == 3'h0) else $error("outputs not idle after reset");
   chk_no_div_pulse: assert property (!div_seen_reg |-> !array_hv_enable)
      else $error("pulse before divider write");
   chk_pulse_code: assert property (array_hv_enable |-> array_op inside {3'h2, 3'h3, 3'h4, 3'h5})
      else $error("pulse without program or erase code");
   chk_target_hold: assert property (array_hv_enable && $past(array_hv_enable)
      |-> $stable(array_op) && $stable(array_eeprom_sel))
      else $error("target changed during pulse");
   chk_latch_hold: assert property (array_hv_enable && $past(array_hv_enable)
      |-> $stable(array_addr) && $stable(array_data))
      else $error("latched address or data changed during pulse");
endmodule // nvct_top_assertions

bind nvct_top nvct_top_assertions chk_i (.clock(clock), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .array_hv_enable(array_hv_enable), .array_eeprom_sel(array_eeprom_sel), .array_op(array_op),
   .array_addr(array_addr), .array_data(array_data), .irq(irq));
`default_nettype wire

// File: tb/nvct_array_model.sv
// nvct_array_model.sv: behavioural flash and eeprom arrays behind the sequencer
// assumes: array_op holds the running code; blank result read during a blank check
`timescale 1ns/1ps
`default_nettype none
module nvct_array_model (
   // clock
   input  wire logic       clock,
   // sequencer side
   input  wire logic       array_hv_enable,
   input  wire logic       array_eeprom_sel,
   input  wire logic [2:0] array_op,
   output var  logic       array_blank
);
   logic [1:0] erased_reg = 2'b00;
   logic       hv_reg     = 1'b0;
   logic [2:0] op_reg     = 3'h0;
   logic       junk_reg   = 1'b0;
   always @(posedge clock) begin
      hv_reg <= array_hv_enable;
      op_reg <= array_op;
      junk_reg <= !junk_reg;
      // blank only once a mass erase has run to its end, per array
      if (hv_reg && !array_hv_enable && op_reg == 3'h5)
         erased_reg[array_eeprom_sel] <= 1'b1;
      if (array_hv_enable && (array_op == 3'h2 || array_op == 3'h3))
         erased_reg[array_eeprom_sel] <= 1'b0;
   end
   // outside a blank check the line means nothing, so it toggles
   assign array_blank = (array_op == 3'h1) ? erased_reg[array_eeprom_sel] : junk_reg;
endmodule // nvct_array_model
`default_nettype wire

// File: tb/tb_nvct_top.sv
// tb_nvct_top.sv: register level bench for the nv command timing block
// assumes: design, checker and array model compiled alongside; 10 MHz clock
`timescale 1ns/1ps
`default_nettype none
`include "nvct_defs.vh"
module tb_nvct_top;
   logic        clock = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, sfetch = 1'b1, dbg = 1'b0;
   logic [7:0]  adr = 8'h00, opt = 8'h80, adat;
   logic [31:0] wdat = 32'h0, rdat, dout;
   logic        ack, hv, esel, blank, secured, irq;
   logic [2:0]  op;
   logic [15:0] aadr;
   int          error_cnt = 0, total_checks = 0, n;
   localparam logic [63:0] KEY = 64'h5A3C_96E1_0F87_D24B; // arbitrary
   always #50 clock = ~clock;
   nvct_top uut (.clock(clock), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack), .secure_code_fetch(sfetch),
      .debug_access(dbg), .backdoor_compare_key(KEY), .nv_option_config(opt), .nv_protect_config(8'hFF),
      .array_hv_enable(hv), .array_eeprom_sel(esel), .array_op(op), .array_addr(aadr), .array_data(adat),
      .array_blank(blank), .secured(secured), .irq(irq));
   nvct_array_model arr (.clock(clock), .array_hv_enable(hv), .array_eeprom_sel(esel), .array_op(op),
      .array_blank(blank));
   task report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // count window allows one timebase of phase slack either side
   task rng(input int len, input int t, input int d);
      chk((len >= t * (d + 1) - d - 1 && len <= t * (d + 1) + d + 1) ? t : len, t);
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      i = 0;
      do begin
         @(posedge clock);
         i++;
      end while (ack !== 1'b1 && i < 20);
      rdat = dout;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (ack !== 1'b1) begin
         error_cnt++;
         report_and_stop;
      end
   endtask
   task rc(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rdat, exp);
   endtask
   task go(input logic [7:0] c);
      bus(1'b1, `NVCT_ADR_ARRAY_ADDR, 32'h1234);
      bus(1'b1, `NVCT_ADR_ARRAY_DATA, 32'hA5);
      bus(1'b1, `NVCT_ADR_COMMAND, {24'h0, c});
   endtask
   task pulse(output int len);
      int i;
      len = 0;
      for (i = 0; i < 50 && hv !== 1'b1; i++)
         @(posedge clock);
      for (len = 0; len < 30000 && hv === 1'b1; len++)
         @(posedge clock);
   endtask
   task rst(input logic [7:0] o);
      rstn <= 1'b0;
      opt <= o;
      repeat (10) @(posedge clock);
      rstn <= 1'b1;
   endtask
   initial begin
      rst(8'h80);
      rc(`NVCT_ADR_STATUS, 32'h0);
      rc(8'h24, 32'h0);
      rc(`NVCT_ADR_SECURITY, 32'h0000FF81);
      bus(1'b1, `NVCT_ADR_IRQ_MASK, 32'h2);
      go(8'h82);
      rc(`NVCT_ADR_STATUS, 32'h2);
      chk(irq, 1'b1);
      bus(1'b1, `NVCT_ADR_STATUS, 32'h2);
      chk(irq, 1'b0);
      rc(`NVCT_ADR_STATUS, 32'h0);
      bus(1'b1, `NVCT_ADR_DIVIDER, 32'h3);
      bus(1'b1, `NVCT_ADR_DIVIDER, 32'h5);
      rc(`NVCT_ADR_DIVIDER, 32'h83);
      bus(1'b1, `NVCT_ADR_IRQ_MASK, 32'h1);
      go(8'h82);
      chk({aadr, adat}, 32'h1234A5);
      pulse(n);
      rng(n, 9, 3);
      chk(irq, 1'b1);
      bus(1'b1, `NVCT_ADR_STATUS, 32'h1);
      go(8'h83);
      pulse(n);
      rng(n, 4, 3);
      for (int k = 0; k < 3; k++) begin
         sfetch <= (k != 1);
         dbg <= (k == 0);
         bus(1'b1, `NVCT_ADR_KEY_LO, KEY[31:0]);
         bus(1'b1, `NVCT_ADR_KEY_HI, KEY[63:32]);
         go(8'h86);
         repeat (6) @(posedge clock);
         chk(secured, k != 2);
      end
      rst(8'h00);
      rc(`NVCT_ADR_DIVIDER, 32'h0);
      rc(`NVCT_ADR_STATUS, 32'h0);
      bus(1'b1, `NVCT_ADR_DIVIDER, 32'h0);
      go(8'h86);
      chk(secured, 1'b1);
      go(8'h8C);
      pulse(n);
      rng(n, 4000, 0);
      go(8'h8C);
      repeat (20) @(posedge clock);
      bus(1'b1, `NVCT_ADR_COMMAND, 32'h4C);
      pulse(n);
      rng(n, 4, 0);
      go(8'h85);
      pulse(n);
      rng(n, 20000, 0);
      go(8'h89);
      repeat (3) @(posedge clock);
      chk(secured, 1'b1);
      go(8'h81);
      repeat (3) @(posedge clock);
      chk(secured, 1'b0);
      rst(8'h02);
      rc(`NVCT_ADR_SECURITY, 32'h0000FF00);
      report_and_stop;
   end
endmodule // tb_nvct_top
`default_nettype wire
